// ==== design/ltc_mode_ctrl.sv ====
// Functional notes
// - Supply undervoltage blocks every dominant drive onto the bus.
// - Power-up enters fail-safe with the regulator switch on, no host action.
// - Bus pull-up on in normal and fail-safe; sleep keeps only weak pull-up.
// - Normal mode: host tx low gives dominant; tx high releases bus.
// - Fail-safe mode: tx pin becomes an output reporting wake source.
// - With guard present, tx low longer than 40 ms forces bus recessive.
// - Timeout clears only after tx held high longer than 10 us.
// - Guard is a build option; without it static low stays dominant.
// - Normal mode: receive output high when recessive, low when dominant.
// - Mode select high means normal mode with both paths active, except in sleep, which it does not leave.
// - Mode select falling with tx high enters sleep, transmission off.
// - Sleep refuses all transmission until a wake-up.
// - Mode select low, including undriven, leads toward sleep.
// - Regulator switch on in normal and in fail-safe without supply undervoltage, off in sleep.
// - Bus or local wake-up turns the regulator switch on unless supply undervoltage is present.
// - Remote wake needs bus dominant for 90 us filter time.
// - Local wake needs local alert low for 35 us filter time.
// - Local wake drives tx pin low with strong pull-down.
// - Any wake request drives receive output low to interrupt host.
// - Fail-safe plus mode select high switches to normal mode.
// - Mode select high clears wake request and wake source at once.
// - After normal entry, driver stays off until tx high over 10 us.
`timescale 1ns/10ps
`default_nettype none
module ltc_mode_ctrl #(
    parameter logic GUARD_EN           = ltc_pkg::GUARD_DEF,
    parameter int   DOM_TIMEOUT_CYCLES = ltc_pkg::DOM_TIMEOUT_CYC
) (
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               mode_select,
    input  wire logic               tx_line_in,
    output var  logic               tx_line_out,
    output var  logic               tx_line_oe,
    output var  logic               rx_line_out,
    output var  logic               rx_line_oe,
    input  wire logic               bus_in,
    output var  logic               bus_drive_dom,
    output var  logic               bus_pullup_en,
    output var  logic               bus_weak_pullup_en,
    input  wire logic               local_alert_in,
    input  wire logic               supply_low_in,
    output var  logic               regulator_switch_out,
    output var  ltc_pkg::ltc_mode_t mode_out
);
    import ltc_pkg::*;

    localparam int DW = $clog2(DOM_TIMEOUT_CYCLES + 2);
    localparam logic [DW-1:0] DOM_LIM = DW'(DOM_TIMEOUT_CYCLES);

    if (DOM_TIMEOUT_CYCLES < 1 || DOM_TIMEOUT_CYCLES > 32'h3FFF_FFFF) begin
        $error("DOM_TIMEOUT_CYCLES out of range");
    end

    function automatic logic [31:0] sat_inc(input logic [31:0] v,
                                            input logic [31:0] lim);
        sat_inc = (v >= lim) ? v : v + 32'h1;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ltc_mode_t                mode_r;
    ltc_mode_t                mode_nxt;
    logic                     ms_prev_r;
    logic                     armed_r;
    logic                     dom_to_r;
    logic [DW-1:0]            tx_lo_cnt_r;
    logic [TX_HIGH_W-1:0]     tx_hi_cnt_r;
    logic [BUS_WAKE_W-1:0]    bus_dom_cnt_r;
    logic [LOCAL_WAKE_W-1:0]  alert_cnt_r;
    logic                     local_armed_r;
    logic                     wake_req_r;
    logic                     wake_local_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire in_sleep  = (mode_r == LTC_SLEEP);
    wire in_fs     = (mode_r == LTC_FAILSAFE);
    wire in_normal = (mode_r == LTC_NORMAL);
    wire ms_fall   = ms_prev_r & ~mode_select;
    wire tx_hi_long = tx_line_in & (tx_hi_cnt_r >= TX_HIGH_LIM);
    wire dom_expire = GUARD_EN & in_normal & ~tx_line_in &
                      (tx_lo_cnt_r >= DOM_LIM);
    // A remote wake needs the dominant phase and then the rising edge.
    wire bus_wake = in_sleep & bus_in &
                    (bus_dom_cnt_r >= BUS_WAKE_LIM);
    // Arming stops a held-low alert from waking the device again.
    wire local_wake = in_sleep & local_armed_r & ~local_alert_in &
                      (alert_cnt_r >= LOCAL_WAKE_LIM);
    wire wake_any = bus_wake | local_wake;

    wire [TX_HIGH_W-1:0] tx_hi_cnt_nxt = (in_normal & tx_line_in) ?
        TX_HIGH_W'(sat_inc(32'(tx_hi_cnt_r), 32'(TX_HIGH_LIM))) : '0;
    wire [DW-1:0] tx_lo_cnt_nxt = (GUARD_EN & in_normal & ~tx_line_in) ?
        DW'(sat_inc(32'(tx_lo_cnt_r), 32'(DOM_LIM))) : '0;
    wire [BUS_WAKE_W-1:0] bus_dom_cnt_nxt = (in_sleep & ~bus_in) ?
        BUS_WAKE_W'(sat_inc(32'(bus_dom_cnt_r), 32'(BUS_WAKE_LIM))) : '0;
    wire [LOCAL_WAKE_W-1:0] alert_cnt_nxt = (in_sleep & ~local_alert_in) ?
        LOCAL_WAKE_W'(sat_inc(32'(alert_cnt_r), 32'(LOCAL_WAKE_LIM))) : '0;
    wire local_armed_nxt = ~local_wake & (local_armed_r | local_alert_in);

    // A new wake wins over a clear landing in the same cycle.
    wire wake_req_nxt = wake_any | (wake_req_r & ~mode_select);
    wire wake_local_nxt = wake_any ? local_wake :
                          (wake_local_r & ~mode_select);

    // ------------------------------------------------------------
    // Mode machine
    // ------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            LTC_SLEEP: begin
                if (wake_any) begin
                    mode_nxt = LTC_FAILSAFE;
                end
            end
            LTC_FAILSAFE: begin
                if (mode_select) begin
                    mode_nxt = LTC_NORMAL;
                end else if (ms_fall & tx_line_in) begin
                    mode_nxt = LTC_SLEEP;
                end
            end
            LTC_NORMAL: begin
                // A low level leaves normal even if the edge was missed.
                if (!mode_select) begin
                    mode_nxt = tx_line_in ? LTC_SLEEP : LTC_FAILSAFE;
                end
            end
            default: begin
                mode_nxt = LTC_FAILSAFE;
            end
        endcase
    end

    wire nx_sleep  = (mode_nxt == LTC_SLEEP);
    wire nx_fs     = (mode_nxt == LTC_FAILSAFE);
    wire nx_normal = (mode_nxt == LTC_NORMAL);

    // The arm step keeps a stuck-low tx from grabbing the bus on entry.
    wire armed_nxt = nx_normal & (armed_r | tx_hi_long);
    wire dom_to_nxt = nx_normal & in_normal &
                      (dom_expire | (dom_to_r & ~tx_hi_long));

    wire drive_nxt = nx_normal & armed_nxt & ~dom_to_nxt &
                     ~supply_low_in & ~tx_line_in;
    wire rx_oe_nxt  = nx_normal ? ~bus_in : (nx_fs & wake_req_nxt);
    wire rx_out_nxt = nx_normal ? bus_in : ~rx_oe_nxt;
    wire tx_oe_nxt  = nx_fs & wake_local_nxt;
    wire reg_nxt = nx_normal | (nx_fs & ~supply_low_in);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_r        <= MODE_RST;
            ms_prev_r     <= 1'b0;
            armed_r       <= 1'b0;
            dom_to_r      <= 1'b0;
            tx_lo_cnt_r   <= '0;
            tx_hi_cnt_r   <= '0;
            bus_dom_cnt_r <= '0;
            alert_cnt_r   <= '0;
            local_armed_r <= 1'b0;
            wake_req_r    <= 1'b0;
            wake_local_r  <= 1'b0;
        end else begin
            mode_r        <= mode_nxt;
            ms_prev_r     <= mode_select;
            armed_r       <= armed_nxt;
            dom_to_r      <= dom_to_nxt;
            tx_lo_cnt_r   <= tx_lo_cnt_nxt;
            tx_hi_cnt_r   <= tx_hi_cnt_nxt;
            bus_dom_cnt_r <= bus_dom_cnt_nxt;
            alert_cnt_r   <= alert_cnt_nxt;
            local_armed_r <= local_armed_nxt;
            wake_req_r    <= wake_req_nxt;
            wake_local_r  <= wake_local_nxt;
        end
    end

    // Outputs are registered from next-state values so they line up
    // with mode_r; the bus path therefore lags tx by one cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bus_drive_dom        <= 1'b0;
            rx_line_out          <= RX_RST;
            rx_line_oe           <= 1'b0;
            tx_line_oe           <= 1'b0;
            regulator_switch_out <= REG_RST;
            bus_pullup_en        <= PULLUP_RST;
            bus_weak_pullup_en   <= ~PULLUP_RST;
        end else begin
            bus_drive_dom        <= drive_nxt;
            rx_line_out          <= rx_out_nxt;
            rx_line_oe           <= rx_oe_nxt;
            tx_line_oe           <= tx_oe_nxt;
            regulator_switch_out <= reg_nxt;
            bus_pullup_en        <= ~nx_sleep;
            bus_weak_pullup_en   <= nx_sleep;
        end
    end

    assign tx_line_out = 1'b0;
    assign mode_out    = mode_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_sleep_req;
        in_normal && !mode_select && tx_line_in;
    endsequence

    sequence s_remote_wake;
        bus_wake && !local_wake;
    endsequence

    sequence s_woken;
        mode_r == LTC_FAILSAFE && rx_line_oe && !rx_line_out;
    endsequence

    AST_UV_BLOCK: assert property (
        supply_low_in |=> !bus_drive_dom)
        else $error("bus driven during undervoltage");

    AST_RESET_FS: assert property (
        $past(reset) |-> mode_r == LTC_FAILSAFE && regulator_switch_out)
        else $error("reset did not give fail-safe with regulator on");

    AST_SLEEP_PULL: assert property (
        in_sleep |-> bus_weak_pullup_en && !bus_pullup_en)
        else $error("pull-up wrong in sleep");

    AST_TX_RECESSIVE: assert property (
        tx_line_in |=> !bus_drive_dom)
        else $error("bus dominant while tx high");

    AST_DOM_TIMEOUT: assert property (
        dom_expire && mode_select |=>
            dom_to_r && !bus_drive_dom ##1 !bus_drive_dom)
        else $error("dominant timeout did not release bus");

    AST_TO_RELEASE: assert property (
        $fell(dom_to_r) && in_normal |-> $past(tx_hi_cnt_r) >= TX_HIGH_LIM)
        else $error("timeout cleared too early");

    AST_RX_MIRROR: assert property (
        in_normal |-> rx_line_out == $past(bus_in))
        else $error("receive output does not follow bus");

    AST_SLEEP_ENTRY: assert property (
        s_sleep_req |=> in_sleep && !bus_drive_dom)
        else $error("sleep not entered");

    AST_SLEEP_REG: assert property (
        in_sleep |-> !regulator_switch_out && !bus_drive_dom)
        else $error("regulator or driver on in sleep");

    AST_REMOTE_WAKE: assert property (
        s_remote_wake |=> s_woken ##0 !tx_line_oe)
        else $error("remote wake not signalled");

    AST_LOCAL_SRC: assert property (
        local_wake |=> mode_r == LTC_FAILSAFE && tx_line_oe && !tx_line_out)
        else $error("local wake source not driven");

    AST_CONFIRM: assert property (
        in_fs && mode_select |=> in_normal && !wake_req_r && !tx_line_oe)
        else $error("confirm did not reach normal or clear flags");

    AST_ARMED: assert property (
        bus_drive_dom |-> armed_r && in_normal)
        else $error("driver on before arming");

    AST_FS_RECESSIVE: assert property (
        in_fs |-> !bus_drive_dom)
        else $error("bus driven outside normal mode");

    AST_SLEEP_HOLD: assert property (
        in_sleep && !wake_any |=> in_sleep)
        else $error("sleep left without a wake");

    AST_NORMAL_EXIT: assert property (
        in_normal && !mode_select && !tx_line_in |=> in_fs)
        else $error("normal kept with mode select low");

    AST_WAKE_REG: assert property (
        wake_any && !supply_low_in |=> regulator_switch_out)
        else $error("wake did not turn regulator on");

    AST_WAKE_RX: assert property (
        wake_any |=> rx_line_oe && !rx_line_out)
        else $error("wake request not signalled on receive");

    AST_WAKE_CLEAR: assert property (
        mode_select && !wake_any |=> !wake_req_r && !wake_local_r)
        else $error("wake flags not cleared by mode select");

endmodule
`default_nettype wire

// ==== design/ltc_pkg.sv ====
`default_nettype none
package ltc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CORE_CLK_HZ    = 20_000_000;
    localparam int DOM_TIMEOUT_MS = 40;
    localparam int TX_HIGH_US     = 10;
    localparam int BUS_WAKE_US    = 90;
    localparam int LOCAL_WAKE_US  = 35;

    localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * (CORE_CLK_HZ / 1000);
    localparam int TX_HIGH_CYC =
        (TX_HIGH_US * CORE_CLK_HZ + 999_999) / 1_000_000;
    localparam int BUS_WAKE_CYC =
        (BUS_WAKE_US * CORE_CLK_HZ + 999_999) / 1_000_000;
    localparam int LOCAL_WAKE_CYC =
        (LOCAL_WAKE_US * CORE_CLK_HZ + 999_999) / 1_000_000;

    localparam int TX_HIGH_W    = $clog2(TX_HIGH_CYC + 2);
    localparam int BUS_WAKE_W   = $clog2(BUS_WAKE_CYC + 2);
    localparam int LOCAL_WAKE_W = $clog2(LOCAL_WAKE_CYC + 2);

    localparam logic [TX_HIGH_W-1:0] TX_HIGH_LIM =
        TX_HIGH_W'(TX_HIGH_CYC);
    localparam logic [BUS_WAKE_W-1:0] BUS_WAKE_LIM =
        BUS_WAKE_W'(BUS_WAKE_CYC);
    localparam logic [LOCAL_WAKE_W-1:0] LOCAL_WAKE_LIM =
        LOCAL_WAKE_W'(LOCAL_WAKE_CYC);

    // ------------------------------------------------------------
    // Modes and reset values
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LTC_SLEEP,
        LTC_FAILSAFE,
        LTC_NORMAL
    } ltc_mode_t;

    localparam ltc_mode_t MODE_RST   = LTC_FAILSAFE;
    localparam logic      GUARD_DEF  = 1'b1;
    localparam logic      REG_RST    = 1'b1;
    localparam logic      PULLUP_RST = 1'b1;
    localparam logic      RX_RST     = 1'b1;

endpackage
`default_nettype wire

// ==== test/ltc_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Bus line model
// ------------------------------------------------------------
// The bus is a wired-AND line with a pull-up. Any node that drives it
// makes it dominant. A released bus reads recessive, never a stale value.
module ltc_bus_model (
    input  wire logic bus_drive_dom,
    input  wire logic other_dom,
    output var  logic bus_in
);
    always_comb begin
        bus_in = ~(bus_drive_dom | other_dom);
    end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench import ltc_pkg::*; ;
    logic      core_clk, reset, mode_select, tx_line_in, local_alert_in;
    logic      supply_low_in, other_dom, bus_in, ng_drive;
    logic      tx_line_out, tx_line_oe, rx_line_out, rx_line_oe;
    logic      bus_drive_dom, bus_pullup_en, bus_weak_pullup_en;
    logic      regulator_switch_out;
    ltc_mode_t mode_out;
    int        err_total;
    int        cmp_count;

    // ------------------------------------------------------------
    // Devices and bus
    // ------------------------------------------------------------
    // The timeout is shortened so the guard scenario stays brief.
    ltc_mode_ctrl #(.GUARD_EN(1'b1), .DOM_TIMEOUT_CYCLES(50)) i_ltc_mode_ctrl (
        .core_clk(core_clk), .reset(reset), .mode_select(mode_select),
        .tx_line_in(tx_line_in), .tx_line_out(tx_line_out),
        .tx_line_oe(tx_line_oe), .rx_line_out(rx_line_out),
        .rx_line_oe(rx_line_oe), .bus_in(bus_in),
        .bus_drive_dom(bus_drive_dom), .bus_pullup_en(bus_pullup_en),
        .bus_weak_pullup_en(bus_weak_pullup_en),
        .local_alert_in(local_alert_in), .supply_low_in(supply_low_in),
        .regulator_switch_out(regulator_switch_out), .mode_out(mode_out));
    // A build without the guard shares every input with the first one.
    ltc_mode_ctrl #(.GUARD_EN(1'b0), .DOM_TIMEOUT_CYCLES(50))
        i_ltc_mode_ctrl_ng (
        .core_clk(core_clk), .reset(reset), .mode_select(mode_select),
        .tx_line_in(tx_line_in), .tx_line_out(), .tx_line_oe(),
        .rx_line_out(), .rx_line_oe(), .bus_in(bus_in),
        .bus_drive_dom(ng_drive), .bus_pullup_en(),
        .bus_weak_pullup_en(), .local_alert_in(local_alert_in),
        .supply_low_in(supply_low_in), .regulator_switch_out(),
        .mode_out());
    ltc_bus_model i_ltc_bus_model (
        .bus_drive_dom(bus_drive_dom),
        .other_dom(other_dom),
        .bus_in(bus_in));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkm(input ltc_mode_t got, input ltc_mode_t exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons=%0d errors=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        cmp_count = 0;
        reset = 1'b1;
        mode_select = 1'b0;
        tx_line_in = 1'b1;
        local_alert_in = 1'b1;
        supply_low_in = 1'b0;
        other_dom = 1'b0;
        step(10);
        reset = 1'b0;
        chkm(mode_out, LTC_FAILSAFE);
        chk(regulator_switch_out, 1'b1);
        chk(bus_pullup_en, 1'b1);
        chk(bus_weak_pullup_en, 1'b0);
        chk(rx_line_out, 1'b1);
        mode_select = 1'b1;
        tx_line_in = 1'b0;
        step(1);
        chkm(mode_out, LTC_NORMAL);
        step(5);
        chk(bus_drive_dom, 1'b0);
        tx_line_in = 1'b1;
        step(210);
        tx_line_in = 1'b0;
        step(2);
        chk(bus_drive_dom, 1'b1);
        chk(rx_line_out, 1'b0);
        supply_low_in = 1'b1;
        step(1);
        chk(bus_drive_dom, 1'b0);
        supply_low_in = 1'b0;
        step(60);
        chk(bus_drive_dom, 1'b0);
        chk(ng_drive, 1'b1);
        tx_line_in = 1'b1;
        step(5);
        tx_line_in = 1'b0;
        step(2);
        chk(bus_drive_dom, 1'b0);
        tx_line_in = 1'b1;
        step(210);
        tx_line_in = 1'b0;
        step(2);
        chk(bus_drive_dom, 1'b1);
        tx_line_in = 1'b1;
        step(2);
        chk(rx_line_out, 1'b1);
        mode_select = 1'b0;
        step(2);
        chkm(mode_out, LTC_SLEEP);
        chk(regulator_switch_out, 1'b0);
        chk(bus_pullup_en, 1'b0);
        chk(bus_weak_pullup_en, 1'b1);
        tx_line_in = 1'b0;
        step(3);
        chk(bus_drive_dom, 1'b0);
        tx_line_in = 1'b1;
        other_dom = 1'b1;
        step(1000);
        other_dom = 1'b0;
        step(3);
        chkm(mode_out, LTC_SLEEP);
        other_dom = 1'b1;
        step(1850);
        other_dom = 1'b0;
        step(2);
        chkm(mode_out, LTC_FAILSAFE);
        chk(regulator_switch_out, 1'b1);
        chk(rx_line_oe, 1'b1);
        chk(rx_line_out, 1'b0);
        chk(bus_pullup_en, 1'b1);
        chk(tx_line_oe, 1'b0);
        mode_select = 1'b1;
        step(1);
        chk(rx_line_oe, 1'b0);
        chkm(mode_out, LTC_NORMAL);
        mode_select = 1'b0;
        step(2);
        chkm(mode_out, LTC_SLEEP);
        local_alert_in = 1'b0;
        step(600);
        local_alert_in = 1'b1;
        step(3);
        chkm(mode_out, LTC_SLEEP);
        local_alert_in = 1'b0;
        step(720);
        chkm(mode_out, LTC_FAILSAFE);
        chk(tx_line_oe, 1'b1);
        chk(tx_line_out, 1'b0);
        chk(rx_line_oe, 1'b1);
        chk(regulator_switch_out, 1'b1);
        mode_select = 1'b1;
        step(1);
        chk(tx_line_oe, 1'b0);
        tx_line_in = 1'b0;
        mode_select = 1'b0;
        step(2);
        chkm(mode_out, LTC_FAILSAFE);
        chk(rx_line_oe, 1'b0);
        chk(tx_line_oe, 1'b0);
        chk(bus_drive_dom, 1'b0);
        chk(regulator_switch_out, 1'b1);
        chk(bus_pullup_en, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
